//--- rtl/rtcv_pkg.sv
// Package with constants and types for the room temperature command value block
package rtcv_pkg;

    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned TICK_SEC_HZ     = 1;
    localparam int unsigned CLK_PER_SEC     = CLK_HZ / TICK_SEC_HZ;
    localparam int unsigned EVAL_PERIOD_SEC = 30;
    localparam int unsigned NUM_LOOPS       = 4;
    localparam int unsigned TEMP_W          = 16;
    localparam int unsigned VAL_W           = 8;

    // Register map, word addresses on the plain register port
    localparam logic [3:0] REG_CTRL      = 4'h0;
    localparam logic [3:0] REG_ALGO      = 4'h1;
    localparam logic [3:0] REG_ROOM_TEMP = 4'h2;
    localparam logic [3:0] REG_SETPOINT  = 4'h3;
    localparam logic [3:0] REG_LEVEL_W   = 4'h4;
    localparam logic [3:0] REG_GAINS     = 4'h5;
    localparam logic [3:0] REG_THRESH    = 4'h6;
    localparam logic [3:0] REG_CYCLE     = 4'h7;
    localparam logic [3:0] REG_HYST      = 4'h8;
    localparam logic [3:0] REG_VALUE_LO  = 4'h9;
    localparam logic [3:0] REG_VALUE_HI  = 4'ha;
    localparam logic [3:0] REG_STATUS    = 4'hb;

    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned CTRL_COOL_BIT = 1;
    localparam int unsigned CTRL_INV_BIT  = 2;

    localparam logic [15:0] CYCLE_RST   = 16'h0258;
    localparam logic [7:0]  THRESH_RST  = 8'h0a;
    localparam logic [15:0] LEVEL_W_RST = 16'h0100;
    localparam logic [15:0] GAINS_RST   = 16'h0408;
    localparam logic [15:0] HYST_RST    = 16'h0040;
    localparam logic [7:0]  VAL_FULL    = 8'hff;

    typedef enum logic [1:0] {
        RTCV_ALG_OFF    = 2'h0,
        RTCV_ALG_PI_CON = 2'h1,
        RTCV_ALG_PI_SW  = 2'h3,
        RTCV_ALG_TWOPT  = 2'h2
    } rtcv_alg_t;

endpackage

//--- rtl/rtcv_loop.sv
// One control loop: PI or two-point value, threshold-gated send and PWM output
`timescale 1ns/1ps
module rtcv_loop
    import rtcv_pkg::*;
#(
    parameter int unsigned CNT_W = 16
) (
    input  wire logic                     clock_i,
    input  wire logic                     sys_rst_i,
    input  wire logic                     eval_i,
    input  wire logic                     sec_i,
    input  wire logic [1:0]               alg_i,
    input  wire logic                     cool_i,
    input  wire logic                     invert_i,
    input  wire logic signed [TEMP_W-1:0] error_i,
    input  wire logic [7:0]               kp_i,
    input  wire logic [7:0]               ki_i,
    input  wire logic [VAL_W-1:0]         thresh_i,
    input  wire logic [TEMP_W-1:0]        hyst_i,
    input  wire logic [CNT_W-1:0]         cycle_sec_i,
    input  wire logic [CNT_W-1:0]         phase_i,
    input  wire logic                     period_end_i,
    output logic [VAL_W-1:0]              value_o,
    output logic                          value_send_o,
    output logic                          switch_o,
    output logic                          switch_send_o,
    output logic [VAL_W-1:0]              status_o,
    output logic                          status_send_o
);
    localparam int ACC_W = 24;

    logic signed [ACC_W-1:0] integ, next_integ;
    logic [VAL_W-1:0]        calc, next_calc;
    logic [VAL_W-1:0]        sent, next_sent;
    logic [VAL_W-1:0]        duty, next_duty;
    logic                    two_on, next_two_on;
    logic                    value_send, next_value_send;
    logic                    sw_send, next_sw_send;
    logic                    sw, next_sw;
    logic                    st_send, next_st_send;

    logic signed [ACC_W-1:0] dev;
    logic signed [ACC_W-1:0] pi_sum;
    logic [VAL_W-1:0]        diff;
    logic [CNT_W+VAL_W-1:0]  on_time;
    logic                    pwm_on;

    always_comb begin
        // Heating demand grows as room falls below setpoint; cooling the reverse
        dev    = cool_i ? ACC_W'(-error_i) : ACC_W'(error_i);
        next_integ      = integ;
        next_calc       = calc;
        next_sent       = sent;
        next_duty       = duty;
        next_two_on     = two_on;
        next_value_send = 1'b0;
        next_sw_send    = 1'b0;
        next_st_send    = 1'b0;
        pi_sum = '0;
        diff   = (calc > sent) ? calc - sent : sent - calc;
        if (eval_i && (alg_i == RTCV_ALG_PI_CON || alg_i == RTCV_ALG_PI_SW)) begin
            next_integ = integ + ACC_W'(dev * $signed({1'b0, ki_i}));
            // Anti-windup: integral part is held between 0 and 0xff00
            if (next_integ < 0)
                next_integ = '0;
            if (next_integ > ACC_W'(32'h0000ff00))
                next_integ = ACC_W'(32'h0000ff00);
            pi_sum = ACC_W'(dev * $signed({1'b0, kp_i})) + next_integ;
            if (pi_sum < 0)
                next_calc = '0;
            else if (pi_sum[ACC_W-1:8] > 0)
                next_calc = VAL_FULL;
            else
                next_calc = pi_sum[7:0];
        end
        if (eval_i && alg_i == RTCV_ALG_TWOPT) begin
            if (dev > ACC_W'($signed({1'b0, hyst_i})))
                next_two_on = 1'b1;
            else if (dev < -ACC_W'($signed({1'b0, hyst_i})))
                next_two_on = 1'b0;
        end
        if (alg_i == RTCV_ALG_PI_CON && diff >= thresh_i && diff != 8'h00) begin
            next_sent       = calc;
            next_value_send = 1'b1;
        end
        if (alg_i == RTCV_ALG_PI_SW && period_end_i) begin
            next_duty    = calc;
            next_sw_send = 1'b1;
            next_st_send = 1'b1;
        end
        if (alg_i == RTCV_ALG_TWOPT && eval_i && next_two_on != two_on)
            next_sw_send = 1'b1;
        // Period end already uses the new duty, so its telegram carries the new level
        on_time = ({{VAL_W{1'b0}}, cycle_sec_i} * {{CNT_W{1'b0}}, next_duty}) / (CNT_W+VAL_W)'(VAL_FULL);
        pwm_on  = (next_duty == VAL_FULL) || ({{VAL_W{1'b0}}, phase_i} < on_time);
        next_sw = (alg_i == RTCV_ALG_TWOPT) ? next_two_on :
                  (alg_i == RTCV_ALG_PI_SW) ? (pwm_on ^ invert_i) : 1'b0;
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            integ      <= '0;
            calc       <= '0;
            sent       <= '0;
            duty       <= '0;
            two_on     <= 1'b0;
            value_send <= 1'b0;
            sw_send    <= 1'b0;
            sw         <= 1'b0;
            st_send    <= 1'b0;
        end else begin
            integ      <= next_integ;
            calc       <= next_calc;
            sent       <= next_sent;
            duty       <= next_duty;
            two_on     <= next_two_on;
            value_send <= next_value_send;
            sw_send    <= next_sw_send;
            sw         <= next_sw;
            st_send    <= next_st_send;
        end
    end

    assign value_o       = sent;
    assign value_send_o  = value_send;
    assign switch_o      = sw;
    assign switch_send_o = sw_send;
    assign status_o      = duty;
    assign status_send_o = st_send;

    logic unused_sec;
    assign unused_sec = sec_i;
endmodule

//--- rtl/rtcv_top.sv
// Room temperature command value block: four loops, shared tick, register port
`timescale 1ns/1ps
// Notes on behaviour
// - Each level selects continuous PI, switching PI or two-point control.
// - Command value comes from active setpoint minus room temperature.
// - Four independent loops: heating basic/additional, cooling basic/additional.
// - Algorithm decides whether output is a 1-bit switch or a 1-byte value.
// - Continuous PI recomputes every 30 seconds.
// - Continuous value is sent only when changed by at least the threshold.
// - Additional level equals basic level with setpoint shifted by level width.
// - Switching PI drives a PWM signal sent each cycle time.
// - Duty factor changes only at the end of a PWM period.
// - Last value of the ended period becomes next duty; earlier ones dropped.
// - Switching PI ignores change threshold and cyclic transmission.
// - At 0 % or 100 % an off or on telegram still follows every cycle.
// - Switching PI publishes its internal continuous value on a status byte.
// - Status bytes update only together with the switching output.
// - All PWM outputs share one common cycle time.
// - Two-point control evaluates every 30 seconds and switches only then.
module rtcv_top
    import rtcv_pkg::*;
#(
    parameter int unsigned CLK_PER_TICK = CLK_PER_SEC,
    parameter int unsigned EVAL_SEC     = EVAL_PERIOD_SEC,
    parameter int unsigned CNT_W        = 16
) (
    input  wire logic                   clock_i,
    input  wire logic                   sys_rst_i,
    input  wire logic [3:0]             reg_addr_i,
    input  wire logic [31:0]            reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic [31:0]                 reg_rdata_o,
    output logic [NUM_LOOPS*VAL_W-1:0]  value_o,
    output logic [NUM_LOOPS-1:0]        value_send_o,
    output logic [NUM_LOOPS-1:0]        thermal_valve_drive_o,
    output logic [NUM_LOOPS-1:0]        switch_send_o,
    output logic [NUM_LOOPS*VAL_W-1:0]  status_o,
    output logic [NUM_LOOPS-1:0]        status_send_o
);
    logic [2:0]        ctrl, next_ctrl;
    logic [7:0]        algo, next_algo;
    logic [TEMP_W-1:0] room, next_room;
    logic [TEMP_W-1:0] setp, next_setp;
    logic [TEMP_W-1:0] lvl_w, next_lvl_w;
    logic [15:0]       gains, next_gains;
    logic [VAL_W-1:0]  thresh, next_thresh;
    logic [CNT_W-1:0]  cycle, next_cycle;
    logic [TEMP_W-1:0] hyst, next_hyst;
    logic [31:0]       rdata, next_rdata;

    logic [31:0]       div, next_div;
    logic              sec, next_sec;
    logic [7:0]        eval_cnt, next_eval_cnt;
    logic              eval, next_eval;
    logic [CNT_W-1:0]  phase, next_phase;
    logic              pend, next_pend;

    // Software writes steer the loops; reads show live loop state
    always_comb begin
        next_ctrl   = ctrl;
        next_algo   = algo;
        next_room   = room;
        next_setp   = setp;
        next_lvl_w  = lvl_w;
        next_gains  = gains;
        next_thresh = thresh;
        next_cycle  = cycle;
        next_hyst   = hyst;
        next_rdata  = 32'h0000_0000;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                REG_CTRL:      next_ctrl   = reg_wdata_i[2:0];
                REG_ALGO:      next_algo   = reg_wdata_i[7:0];
                REG_ROOM_TEMP: next_room   = reg_wdata_i[TEMP_W-1:0];
                REG_SETPOINT:  next_setp   = reg_wdata_i[TEMP_W-1:0];
                REG_LEVEL_W:   next_lvl_w  = reg_wdata_i[TEMP_W-1:0];
                REG_GAINS:     next_gains  = reg_wdata_i[15:0];
                REG_THRESH:    next_thresh = reg_wdata_i[VAL_W-1:0];
                REG_CYCLE:     next_cycle  = reg_wdata_i[CNT_W-1:0];
                REG_HYST:      next_hyst   = reg_wdata_i[TEMP_W-1:0];
                default:       next_ctrl   = ctrl;
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                REG_CTRL:      next_rdata = {29'h0, ctrl};
                REG_ALGO:      next_rdata = {24'h0, algo};
                REG_ROOM_TEMP: next_rdata = {16'h0, room};
                REG_SETPOINT:  next_rdata = {16'h0, setp};
                REG_LEVEL_W:   next_rdata = {16'h0, lvl_w};
                REG_GAINS:     next_rdata = {16'h0, gains};
                REG_THRESH:    next_rdata = {24'h0, thresh};
                REG_CYCLE:     next_rdata = {16'h0, cycle};
                REG_HYST:      next_rdata = {16'h0, hyst};
                REG_VALUE_LO:  next_rdata = status_o;
                REG_VALUE_HI:  next_rdata = value_o;
                REG_STATUS:    next_rdata = {20'h0, phase[7:0], thermal_valve_drive_o};
                default:       next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Seconds tick, 30 s evaluation tick and the shared PWM phase
    always_comb begin
        next_sec      = 1'b0;
        next_eval     = 1'b0;
        next_pend     = 1'b0;
        next_div      = div + 32'h1;
        next_eval_cnt = eval_cnt;
        next_phase    = phase;
        if (div >= 32'(CLK_PER_TICK - 1)) begin
            next_div = 32'h0;
            next_sec = 1'b1;
        end
        if (sec) begin
            if (eval_cnt >= 8'(EVAL_SEC - 1)) begin
                next_eval_cnt = 8'h00;
                next_eval     = 1'b1;
            end else
                next_eval_cnt = eval_cnt + 8'h01;
            if (phase >= cycle - CNT_W'(1)) begin
                next_phase = '0;
                next_pend  = 1'b1;
            end else
                next_phase = phase + CNT_W'(1);
        end
        if (!ctrl[CTRL_EN_BIT]) begin
            next_eval  = 1'b0;
            next_pend  = 1'b0;
            next_phase = '0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ctrl     <= 3'h0;
            algo     <= 8'h00;
            room     <= '0;
            setp     <= '0;
            lvl_w    <= LEVEL_W_RST;
            gains    <= GAINS_RST;
            thresh   <= THRESH_RST;
            cycle    <= CYCLE_RST;
            hyst     <= HYST_RST;
            rdata    <= 32'h0000_0000;
            div      <= 32'h0;
            sec      <= 1'b0;
            eval_cnt <= 8'h00;
            eval     <= 1'b0;
            phase    <= '0;
            pend     <= 1'b0;
        end else begin
            ctrl     <= next_ctrl;
            algo     <= next_algo;
            room     <= next_room;
            setp     <= next_setp;
            lvl_w    <= next_lvl_w;
            gains    <= next_gains;
            thresh   <= next_thresh;
            cycle    <= next_cycle;
            hyst     <= next_hyst;
            rdata    <= next_rdata;
            div      <= next_div;
            sec      <= next_sec;
            eval_cnt <= next_eval_cnt;
            eval     <= next_eval;
            phase    <= next_phase;
            pend     <= next_pend;
        end
    end

    assign reg_rdata_o = rdata;

    // Loop k: bit0 = additional level, bit1 = cooling
    genvar k;
    generate
        for (k = 0; k < NUM_LOOPS; k++) begin : g_loop
            logic signed [TEMP_W-1:0] err;
            logic [1:0]               alg;
            logic                     is_cool;
            logic                     active;
            assign is_cool = (k >= 2);
            assign active  = (ctrl[CTRL_COOL_BIT] == is_cool);
            assign alg     = active ? algo[2*k+1:2*k] : RTCV_ALG_OFF;
            // Additional level shifts its setpoint away by the level width
            assign err = (k % 2 == 0) ? $signed(setp - room) :
                         (is_cool ? $signed(setp + lvl_w - room)
                                  : $signed(setp - lvl_w - room));
            rtcv_loop #(
                .CNT_W (CNT_W)
            ) u_loop (
                .clock_i       (clock_i),
                .sys_rst_i     (sys_rst_i),
                .eval_i        (eval),
                .sec_i         (sec),
                .alg_i         (alg),
                .cool_i        (is_cool),
                .invert_i      (ctrl[CTRL_INV_BIT]),
                .error_i       (err),
                .kp_i          (gains[15:8]),
                .ki_i          (gains[7:0]),
                .thresh_i      (thresh),
                .hyst_i        (hyst),
                .cycle_sec_i   (cycle),
                .phase_i       (phase),
                .period_end_i  (pend),
                .value_o       (value_o[k*VAL_W +: VAL_W]),
                .value_send_o  (value_send_o[k]),
                .switch_o      (thermal_valve_drive_o[k]),
                .switch_send_o (switch_send_o[k]),
                .status_o      (status_o[k*VAL_W +: VAL_W]),
                .status_send_o (status_send_o[k])
            );
        end
    endgenerate
endmodule

//--- verif/rtcv_top_asserts.sv
// Port-level checks for the room temperature command value block
`timescale 1ns/1ps
module rtcv_top_asserts
    import rtcv_pkg::*;
#(
    parameter int unsigned CLK_PER_TICK = CLK_PER_SEC,
    parameter int unsigned EVAL_SEC     = EVAL_PERIOD_SEC,
    parameter int unsigned CNT_W        = 16
) (
    input wire logic                  clock_i,
    input wire logic                  sys_rst_i,
    input wire logic [3:0]            reg_addr_i,
    input wire logic [31:0]           reg_wdata_i,
    input wire logic                  reg_wr_i,
    input wire logic                  reg_rd_i,
    input wire logic [31:0]           reg_rdata_o,
    input wire logic [NUM_LOOPS*VAL_W-1:0] value_o,
    input wire logic [NUM_LOOPS-1:0]  value_send_o,
    input wire logic [NUM_LOOPS-1:0]  thermal_valve_drive_o,
    input wire logic [NUM_LOOPS-1:0]  switch_send_o,
    input wire logic [NUM_LOOPS*VAL_W-1:0] status_o,
    input wire logic [NUM_LOOPS-1:0]  status_send_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    // Read data only in the cycle after a mapped read
    a_rdata_idle_zero: assert property ((!$past(reg_rd_i) || $past(reg_addr_i) > 4'hb) |-> reg_rdata_o == 32'h0)
        else $error("read data not zero outside a mapped read answer");
    a_status_with_switch: assert property (status_send_o[1] |-> switch_send_o[1])
        else $error("status byte sent without switching telegram");
    a_status_send_pulse: assert property (status_send_o[1] |=> !status_send_o[1])
        else $error("status send longer than one cycle");
    a_value_send_spacing: assert property (value_send_o[0] |=> !value_send_o[0] [*8])
        else $error("continuous value sent again before next evaluation");
    a_switch_send_spacing: assert property (switch_send_o[1] |=> !switch_send_o[1] [*8])
        else $error("switching telegram repeated inside one period");
    a_status_only_sent: assert property ($changed(status_o[15:8]) |-> status_send_o[1] || $past(status_send_o[1]))
        else $error("status byte changed away from a period end");
    a_full_duty_on: assert property ((status_send_o[1] && status_o[15:8] == 8'hff) |-> ##[1:2] thermal_valve_drive_o[1] [*3])
        else $error("full duty did not hold the output on");
    a_zero_duty_off: assert property ((status_send_o[1] && status_o[15:8] == 8'h00) |-> ##[1:2] !thermal_valve_drive_o[1] [*3])
        else $error("zero duty did not hold the output off");
endmodule

bind rtcv_top rtcv_top_asserts #(.CLK_PER_TICK(CLK_PER_TICK), .EVAL_SEC(EVAL_SEC), .CNT_W(CNT_W)) u_chk (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .value_o(value_o),
    .value_send_o(value_send_o), .thermal_valve_drive_o(thermal_valve_drive_o),
    .switch_send_o(switch_send_o), .status_o(status_o), .status_send_o(status_send_o));

//--- verif/rtcv_actuator.sv
// Switch actuator model that follows switching telegrams from the controller
`timescale 1ns/1ps
module rtcv_actuator (
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic [3:0]  drive_i,
    input  wire logic [3:0]  send_i,
    output logic [3:0]       state_o,
    output logic [63:0]      tel_count_o
);
    // Only a telegram moves the valve; the level between telegrams is ignored
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_o     <= 4'h0;
            tel_count_o <= 64'h0;
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (send_i[k]) begin
                    state_o[k]             <= drive_i[k];
                    tel_count_o[16*k +: 16] <= tel_count_o[16*k +: 16] + 16'h1;
                end
            end
        end
    end
endmodule

//--- verif/rtcv_top_bench.sv
// Self-checking bench for the room temperature command value block
`timescale 1ns/1ps
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module rtcv_top_bench;
    import rtcv_pkg::*;
    typedef struct { logic wr; logic [3:0] addr; logic [31:0] data; } rtcv_row_t;
    logic        clock_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [3:0]  reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rd;
    logic [31:0] value_o, status_o;
    logic [3:0]  value_send_o, thermal_valve_drive_o, switch_send_o, status_send_o, act_state;
    logic [63:0] act_count;
    logic [7:0]  last_sent = 8'h00, jump;
    logic        twopt_watch = 1'b0, prev_drive = 1'b0;
    int          mismatches = 0, tests_run = 0, bad_edges = 0, pi_sw_values = 0;
    time         t1;
    logic [15:0] c0;
    rtcv_row_t   rows [10] = '{'{0, 4'h4, 32'h100}, '{0, 4'h5, 32'h408}, '{0, 4'h6, 32'h0a},
        '{0, 4'h7, 32'h258}, '{0, 4'h8, 32'h40}, '{0, 4'hc, 32'h0}, '{1, 4'h7, 32'h4},
        '{0, 4'h7, 32'h4}, '{1, 4'hc, 32'h55}, '{0, 4'hc, 32'h0}};

    always #20 clock_i = ~clock_i;

    rtcv_top #(.CLK_PER_TICK(4), .EVAL_SEC(3), .CNT_W(16)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .value_o(value_o), .value_send_o(value_send_o),
        .thermal_valve_drive_o(thermal_valve_drive_o), .switch_send_o(switch_send_o),
        .status_o(status_o), .status_send_o(status_send_o));
    rtcv_actuator u_act (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .drive_i(thermal_valve_drive_o),
        .send_i(switch_send_o), .state_o(act_state), .tel_count_o(act_count));

    // Threshold on continuous sends, no byte sends from a switching loop, two-point edges
    always @(posedge clock_i) begin
        if (!sys_rst_i && value_send_o[0] === 1'b1) begin
            jump = value_o[7:0] > last_sent ? value_o[7:0] - last_sent : last_sent - value_o[7:0];
            `CHECK(jump >= THRESH_RST, 1'b1)
            last_sent = value_o[7:0];
        end
        if (value_send_o[1] === 1'b1)
            pi_sw_values++;
        if (twopt_watch && thermal_valve_drive_o[0] !== prev_drive && switch_send_o[0] !== 1'b1)
            bad_edges++;
        prev_drive = thermal_valve_drive_o[0];
    end

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock_i);
        reg_addr_i <= a; reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    task automatic give_verdict();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // 0/3: status send of loop 1/2 at value v, 1: telegram of loop 1, 2: loop 0 drive equals v[0]
    task automatic wait_until(input int which, input logic [7:0] v, input int limit);
        for (int i = 0; i < limit; i++) begin
            @(posedge clock_i);
            #1;
            if ((which == 0 && status_send_o[1] === 1'b1 && status_o[15:8] === v) ||
                (which == 1 && switch_send_o[1] === 1'b1) || (which == 2 && thermal_valve_drive_o[0] === v[0]) ||
                (which == 3 && status_send_o[2] === 1'b1 && status_o[23:16] === v))
                return;
        end
        mismatches++;
        $display("BAD t=%0t got=%h exp=%h", $time, which, v);
        give_verdict();
    endtask

    initial begin
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        #1 `CHECK({value_o, status_o, thermal_valve_drive_o}, 68'h0)
        foreach (rows[i]) begin
            if (rows[i].wr)
                reg_write(rows[i].addr, rows[i].data);
            else begin
                reg_read(rows[i].addr, rd);
                `CHECK(rd, rows[i].data)
            end
        end
        // Strong heating demand: both heating levels saturate
        reg_write(REG_ROOM_TEMP, 32'h0);
        reg_write(REG_SETPOINT, 32'h4000);
        reg_write(REG_ALGO, 32'h0d);
        reg_write(REG_CTRL, 32'h1);
        wait_until(0, 8'hff, 4000);
        wait_until(1, 8'h0, 40);
        t1 = $time;
        c0 = act_count[31:16];
        wait_until(1, 8'h0, 40);
        `CHECK(($time - t1) / 40, 16)
        wait_until(1, 8'h0, 40);
        @(posedge clock_i);
        #1 `CHECK(act_state[1], 1'b1)
        `CHECK(act_count[31:16], c0 + 16'h3)
        `CHECK(value_o[7:0], 8'hff)
        `CHECK(pi_sw_values, 0)
        // No demand: duty reaches zero, telegrams keep coming
        reg_write(REG_ROOM_TEMP, 32'h4000);
        reg_write(REG_SETPOINT, 32'h0);
        wait_until(0, 8'h00, 8000);
        c0 = act_count[31:16];
        wait_until(1, 8'h0, 40);
        wait_until(1, 8'h0, 40);
        @(posedge clock_i);
        #1 `CHECK(act_state[1], 1'b0)
        `CHECK(act_count[31:16], c0 + 16'h3)
        // Small demand reaches the basic level but not the shifted additional level
        reg_write(REG_ROOM_TEMP, 32'hff80);
        wait_until(1, 8'h0, 40);
        wait_until(1, 8'h0, 40);
        `CHECK(value_o[7:0], VAL_FULL)
        `CHECK(status_o[15:8], 8'h00)
        // Two-point on loop 0: switches only with its telegram
        reg_write(REG_ALGO, 32'h0e);
        twopt_watch = 1'b1;
        reg_write(REG_ROOM_TEMP, 32'h0);
        reg_write(REG_SETPOINT, 32'h4000);
        wait_until(2, 8'h1, 200);
        reg_write(REG_ROOM_TEMP, 32'h7000);
        wait_until(2, 8'h0, 200);
        `CHECK(bad_edges, 0)
        // Cooling with inverted output: loop 2 at full demand keeps its drive low
        reg_write(REG_ALGO, 32'h30);
        reg_write(REG_CTRL, 32'h7);
        wait_until(3, 8'hff, 400);
        `CHECK(thermal_valve_drive_o[2], 1'b0)
        `CHECK(thermal_valve_drive_o[1:0], 2'h0)
        // Reset in mid-run clears all outputs
        twopt_watch = 1'b0;
        @(posedge clock_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        #1 `CHECK({value_o, status_o, thermal_valve_drive_o}, 68'h0)
        give_verdict();
    end
endmodule
